// ===== verilog/ipi_pkg.sv
/*
 * constants and types shared by the interrupt pin interface.
 * assumes a single 50 MHz clock and an asynchronous active-low reset.
 */
// Operation
// R1 - requests synchronized, edge or level triggered
// R2 - requester holds line until serviced
// R3 - unmasked request vectors to its table entry
// R4 - cascade on input zero: pin two acknowledges
// R5 - acknowledge outputs fetch type from system
// R6 - requesting peripheral supplies type on acknowledge
// R7 - cascade on input one: pin three acknowledges
// R8 - slave mode: pin three is request output
// R9 - slave select marks type on bus
// R10 - master requests on input zero first
// R11 - rising nmi edge, top priority, unmasked
// R12 - nmi service starts at instruction boundary
// R13 - nmi held high one clock period
// R14 - nmi has no pending flag, can preempt
// R15 - taking any interrupt clears enable flag
// R16 - maskable priority ignores nmi in service
// R17 - data strobe asserted during acknowledge cycle
// R18 - per-input trigger, mask and mode controls
package ipi_pkg;
    localparam int NUM_REQ = 5;
    localparam logic [7:0] NMI_TYPE = 8'h02;
    localparam logic [7:0] REQ_TYPE_BASE = 8'h0c;
    localparam int TYPE_W = 8;
    // acknowledge cycle length in clocks
    localparam logic [1:0] ACK_CYCLES = 2'h2;

    typedef enum logic [1:0] {IPI_NORMAL, IPI_CASCADE, IPI_SLAVE} ipi_mode_t;
    typedef enum {IPI_IDLE, IPI_ACK, IPI_WAIT_SEL, IPI_TAKE} ipi_state_t;
endpackage : ipi_pkg

// ===== verilog/ipi_sync_if.sv
/*
 * carrier between the top and its synchronizer.
 * assumes both ends share one clock.
 */
interface ipi_sync_if #(parameter int W = 7);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport top (output raw, input sync);
    modport syn (input raw, output sync);
endinterface : ipi_sync_if

// ===== verilog/ipi_sync.sv
/*
 * two-flop synchronizer bank for asynchronous pins.
 * assumes inputs may change at any time.
 */
module ipi_sync #(
    parameter int W = 7
) (
    input wire logic clk,
    input wire logic nrst,
    ipi_sync_if.syn bus
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } ipi_sync_st_t;
    ipi_sync_st_t r;
    ipi_sync_st_t next_r;

    // first stage feeds only the second
    always_comb
    begin
        next_r.meta = bus.raw;
        next_r.sync = r.meta;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            r <= '0;
        else
            r <= next_r;
    end

    assign bus.sync = r.sync;
endmodule : ipi_sync

// ===== verilog/ipi_top.sv
/*
 * interrupt pin interface: five maskable requests, one nmi, normal,
 * cascade and slave arrangements, vector type output to the core.
 * assumes the core pulses instr_boundary and re-enables via if_set.
 * ad_in is taken unsynchronized: it must stand while select or ack is low.
 */
module ipi_top
    import ipi_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [4:0] request_pin_in,
    input wire logic nmi_pin,
    input wire logic slave_select_n,
    input wire logic [7:0] ad_in,
    input wire logic [4:0] level_trigger,
    input wire logic [4:0] req_mask,
    input wire logic [1:0] mode_sel,
    input wire logic [1:0] cascade_en,
    input wire logic instr_boundary,
    input wire logic if_set,
    input wire logic [4:0] service_done,
    output logic cascade_ack_0_n,
    output logic cascade_ack_1_n,
    output logic pin2_oe_n,
    output logic pin3_oe_n,
    output logic slave_irq,
    output logic data_enable_n,
    output logic int_take,
    output logic [7:0] int_type,
    output logic int_enable,
    output logic [4:0] pending
);
    typedef struct packed {
        ipi_state_t st;
        logic [4:0] prev;
        logic [4:0] pend;
        logic nmi_prev;
        logic nmi_req;
        logic ie;
        logic [2:0] src;
        logic [1:0] cnt;
        logic ack0_n;
        logic ack1_n;
        logic irq;
        logic den_n;
        logic take;
        logic [7:0] ty;
        logic oe2_n;
        logic oe3_n;
    } ipi_st_t;
    ipi_st_t r;
    ipi_st_t next_r;
    ipi_sync_if #(.W(7)) sif ();
    logic [4:0] req_s;
    logic nmi_s;
    logic sel_n_s;
    logic [4:0] live;
    logic casc0;
    logic casc1;
    logic slave;

    // the synchronizer bank and the pin ports are cut for five requests
    if (NUM_REQ != 5)
    begin : g_bad_count
        $error("ipi_top serves exactly five request inputs");
    end

    // every pin input except ad_in passes two flops before use
    assign sif.raw = {slave_select_n, nmi_pin, request_pin_in}; // R1
    ipi_sync #(.W(7)) u_sync (.clk(clk), .nrst(nrst), .bus(sif.syn));
    assign req_s = sif.sync[4:0];
    assign nmi_s = sif.sync[5];
    assign sel_n_s = sif.sync[6];

    // pin-function decode
    assign slave = (ipi_mode_t'(mode_sel) == IPI_SLAVE); // R18
    assign casc0 = (ipi_mode_t'(mode_sel) == IPI_CASCADE) && cascade_en[0];
    assign casc1 = (ipi_mode_t'(mode_sel) == IPI_CASCADE) && cascade_en[1];

    // lowest-numbered unmasked pending request wins
    function automatic logic [2:0] pick(input logic [4:0] p);
        pick = 3'h7;
        for (int i = NUM_REQ - 1; i >= 0; i--)
            if (p[i])
                pick = i[2:0];
    endfunction : pick

    // one next-state image of the whole block
    always_comb
    begin
        next_r = r;
        next_r.take = 1'b0;
        next_r.prev = req_s;
        next_r.nmi_prev = nmi_s;
        next_r.oe2_n = !casc0; // R4
        next_r.oe3_n = !(casc1 || slave); // R7 R8
        live = req_s;
        // pins turned into outputs no longer request
        if (casc0)
            live[2] = 1'b0;
        if (casc1 || slave)
            live[3] = 1'b0;
        // edge or level capture; set beats service clear
        for (int i = 0; i < NUM_REQ; i++)
        begin
            if (service_done[i])
                next_r.pend[i] = 1'b0;
            if (level_trigger[i] ? live[i] : (live[i] && !r.prev[i]))
                next_r.pend[i] = 1'b1; // R1
            if (level_trigger[i] && !live[i])
                next_r.pend[i] = 1'b0;
        end
        // nmi latched on rising edge, no mask, no pending flag
        if (nmi_s && !r.nmi_prev)
            next_r.nmi_req = 1'b1; // R11 R14
        if (if_set)
            next_r.ie = 1'b1;
        case (r.st)
            IPI_IDLE:
            begin
                // nothing starts off a boundary; a take pulse is never stretched
                if (r.nmi_req && instr_boundary && !r.take)
                begin
                    // nmi preempts regardless of ie or service in progress
                    // a fresh edge in this same cycle stays latched for later
                    next_r.nmi_req = nmi_s && !r.nmi_prev; // R12 R14
                    next_r.ty = NMI_TYPE; // R11
                    next_r.take = 1'b1;
                    next_r.ie = 1'b0; // R15
                end
                else if (r.ie && instr_boundary && |(r.pend & ~req_mask))
                begin
                    // nmi service state is never consulted here
                    next_r.src = pick(r.pend & ~req_mask); // R16
                    if (slave)
                    begin
                        next_r.irq = 1'b1; // R8
                        next_r.st = IPI_WAIT_SEL;
                    end
                    else if ((pick(r.pend & ~req_mask) == 3'h0 && casc0) ||
                             (pick(r.pend & ~req_mask) == 3'h1 && casc1))
                    begin
                        next_r.ack0_n = !(pick(r.pend & ~req_mask) == 3'h0); // R5
                        next_r.ack1_n = !(pick(r.pend & ~req_mask) == 3'h1); // R5
                        next_r.den_n = 1'b0; // R17
                        next_r.cnt = ACK_CYCLES;
                        next_r.st = IPI_ACK;
                    end
                    else
                    begin
                        next_r.ty = REQ_TYPE_BASE + {5'h00, pick(r.pend & ~req_mask)}; // R3
                        next_r.st = IPI_TAKE;
                    end
                end
            end
            IPI_ACK:
            begin
                // peripheral drives type during the acknowledge
                next_r.cnt = r.cnt - 2'h1;
                if (r.cnt == 2'h1)
                begin
                    next_r.ty = ad_in; // R6
                    next_r.ack0_n = 1'b1;
                    next_r.ack1_n = 1'b1;
                    next_r.den_n = 1'b1; // R17
                    next_r.st = IPI_TAKE;
                end
            end
            IPI_WAIT_SEL:
            begin
                // master has the type on the bus once select falls
                // select has crossed two flops, so the bus is settled by now
                if (!sel_n_s)
                begin
                    next_r.ty = ad_in; // R9
                    next_r.irq = 1'b0;
                    next_r.st = IPI_TAKE;
                end
            end
            IPI_TAKE:
            begin
                // pulse and enable clear land on the same edge
                next_r.take = 1'b1;
                next_r.ie = 1'b0; // R15
                next_r.st = IPI_IDLE;
            end
            default:
                next_r.st = IPI_IDLE;
        endcase
    end

    // active-low outputs idle high through reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r <= '0;
            r.st <= IPI_IDLE;
            r.ack0_n <= 1'b1;
            r.ack1_n <= 1'b1;
            r.den_n <= 1'b1;
            r.oe2_n <= 1'b1;
            r.oe3_n <= 1'b1;
        end
        else
            r <= next_r;
    end

    // every output straight from the state register
    assign cascade_ack_0_n = r.ack0_n;
    assign cascade_ack_1_n = r.ack1_n;
    assign pin2_oe_n = r.oe2_n;
    assign pin3_oe_n = r.oe3_n;
    assign slave_irq = r.irq;
    assign data_enable_n = r.den_n;
    assign int_take = r.take;
    assign int_type = r.ty;
    assign int_enable = r.ie;
    assign pending = r.pend;
endmodule : ipi_top

// ===== bench/ipi_props.sv
/* checker on the pin interface top ports.
   assumes one clock and the active-low asynchronous reset. */
module ipi_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic slave_select_n,
    input wire logic [1:0] mode_sel,
    input wire logic [1:0] cascade_en,
    input wire logic cascade_ack_0_n,
    input wire logic cascade_ack_1_n,
    input wire logic pin2_oe_n,
    input wire logic pin3_oe_n,
    input wire logic slave_irq,
    input wire logic data_enable_n,
    input wire logic int_take,
    input wire logic int_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so clock and reset are stated once
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_take_clears_ie: assert property (int_take |-> !int_enable)
        else $error("take left enable set");
    a_take_one_cycle: assert property (int_take |=> !int_take)
        else $error("take longer than one cycle");
    a_ack0_width: assert property (
        $fell(cascade_ack_0_n) |=> !cascade_ack_0_n ##1 cascade_ack_0_n)
        else $error("ack0 width wrong");
    a_ack1_width: assert property (
        $fell(cascade_ack_1_n) |=> !cascade_ack_1_n ##1 cascade_ack_1_n)
        else $error("ack1 width wrong");
    a_den_on_ack: assert property (!cascade_ack_0_n || !cascade_ack_1_n |-> !data_enable_n)
        else $error("strobe missing in ack");
    a_pin2_role: assert property (
        1 |=> pin2_oe_n == !($past(mode_sel) == 2'h1 && $past(cascade_en[0])))
        else $error("pin2 direction wrong");
    a_pin3_role: assert property (
        1 |=> pin3_oe_n == !(($past(mode_sel) == 2'h1 && $past(cascade_en[1]))
        || $past(mode_sel) == 2'h2))
        else $error("pin3 direction wrong");
    a_irq_holds: assert property (slave_irq && slave_select_n |=> slave_irq)
        else $error("slave request dropped early");
endmodule : ipi_props

bind ipi_top ipi_props u_props (.clk, .nrst, .slave_select_n, .mode_sel, .cascade_en,
    .cascade_ack_0_n, .cascade_ack_1_n, .pin2_oe_n, .pin3_oe_n, .slave_irq,
    .data_enable_n, .int_take, .int_enable);

// ===== bench/ipi_peer.sv
/* far side: cascade peripherals on inputs 0 and 1, and the slave-mode master.
   assumes the bench pulses fire to start a request. */
module ipi_peer #(parameter logic [7:0] T0 = 8'h40, T1 = 8'h41, TS = 8'h60) (
    input wire logic clk,
    input wire logic [1:0] fire,
    input wire logic cascade_ack_0_n,
    input wire logic cascade_ack_1_n,
    input wire logic slave_irq,
    output logic [1:0] req = 2'h0,
    output logic slave_select_n = 1'b1,
    output logic [7:0] ad_in = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released bus never keeps its last value, so stale types cannot pass
    always_ff @(posedge clk)
    begin
        ad_in <= ~ad_in;
        req[0] <= (req[0] & cascade_ack_0_n & !slave_irq) | fire[0];
        req[1] <= (req[1] & cascade_ack_1_n) | fire[1];
        slave_select_n <= !slave_irq;
        if (!cascade_ack_0_n) ad_in <= T0;
        if (!cascade_ack_1_n) ad_in <= T1;
        if (slave_irq) ad_in <= TS;
    end
endmodule : ipi_peer

// ===== bench/ipi_top_tb.sv
/* self-checking bench for ipi_top with the far-side model.
   assumes the boundary strobe is high except where a scenario holds it off. */
`define CHK(n, e, a) check_count++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %h got %h", n, e, a); end
module ipi_top_tb
    import ipi_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, nrst = 0, nmi = 0, ifs = 0, sel_n, ack0_n, ack1_n, irq, take, ie, p2, p3;
    logic [4:0] req = 5'h00, msk = 5'h00, done = 5'h00, lvl = 5'h00, pend;
    logic bnd = 1'b1;
    logic [1:0] mode = 2'h0, cen = 2'h0, fire = 2'h0, peer_req;
    logic [7:0] ad, ty;
    int n_errors = 0, check_count = 0;
    initial forever #10 clk = ~clk;
    ipi_peer u_peer (.clk, .fire, .cascade_ack_0_n(ack0_n), .cascade_ack_1_n(ack1_n),
        .slave_irq(irq), .req(peer_req), .slave_select_n(sel_n), .ad_in(ad));
    ipi_top u_dut (.clk, .nrst, .request_pin_in({req[4:2], peer_req}), .nmi_pin(nmi),
        .slave_select_n(sel_n), .ad_in(ad), .level_trigger(lvl), .req_mask(msk),
        .mode_sel(mode), .cascade_en(cen), .instr_boundary(bnd), .if_set(ifs),
        .service_done(done), .cascade_ack_0_n(ack0_n), .cascade_ack_1_n(ack1_n),
        .pin2_oe_n(p2), .pin3_oe_n(p3), .slave_irq(irq), .data_enable_n(),
        .int_take(take), .int_type(ty), .int_enable(ie), .pending(pend));
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // enable and requests land on one edge, so the order never matters
    task automatic kick(input logic [4:0] r, input logic [1:0] f);
        @(posedge clk);
        ifs <= 1'b1;
        fire <= f;
        req <= r;
        @(posedge clk);
        ifs <= 1'b0;
        fire <= 2'h0;
    endtask : kick
    // bounded wait for a take, then retire the source
    task automatic take_is(input logic [7:0] t, input logic [4:0] d);
        int i;
        for (i = 0; i < 40 && take !== 1'b1; i++)
            @(negedge clk);
        if (i == 40)
        begin
            n_errors++;
            tally_and_finish();
        end
        `CHK("type", t, ty)
        `CHK("enable", 1'b0, ie)
        @(posedge clk);
        done <= d;
        req <= req & ~d;
        @(posedge clk);
        done <= 5'h00;
    endtask : take_is
    task automatic quiet(input int n);
        repeat (n)
        begin
            @(negedge clk);
            `CHK("take", 1'b0, take)
        end
    endtask : quiet
    // lowest unmasked index first; enable flag gates the next one
    task automatic t_normal;
        msk <= 5'h08;
        kick(5'h1c, 2'h0);
        take_is(REQ_TYPE_BASE + 8'h02, 5'h04);
        quiet(8);
        `CHK("pending", 5'h18, pend)
        kick(5'h18, 2'h0);
        take_is(REQ_TYPE_BASE + 8'h04, 5'h10);
        kick(5'h08, 2'h0);
        quiet(8);
    endtask : t_normal
    // two nmi edges, the first with the enable flag still set from t_normal, the second with it clear
    task automatic t_nmi;
        repeat (2)
        begin
            @(posedge clk);
            nmi <= 1'b1;
            repeat (2) @(posedge clk);
            nmi <= 1'b0;
            take_is(NMI_TYPE, 5'h00);
        end
    endtask : t_nmi
    task automatic t_cascade;
        mode <= 2'h1;
        cen <= 2'h3;
        kick(5'h00, 2'h1);
        @(negedge clk);
        `CHK("pin2 oe", 1'b0, p2)
        `CHK("pin3 oe", 1'b0, p3)
        take_is(8'h40, 5'h01);
        kick(5'h00, 2'h2);
        take_is(8'h41, 5'h02);
    endtask : t_cascade
    task automatic t_slave;
        mode <= 2'h2;
        cen <= 2'h0;
        kick(5'h00, 2'h1);
        @(negedge clk);
        `CHK("pin2 oe", 1'b1, p2)
        `CHK("pin3 oe", 1'b0, p3)
        take_is(8'h60, 5'h01);
    endtask : t_slave
    // mid-run reset in slave mode: acks, pin3 oe, slave irq, enable and pending back to their idle levels
    task automatic t_reset;
        @(posedge clk);
        nrst <= 1'b0;
        @(negedge clk);
        `CHK("ack0", 1'b1, ack0_n)
        `CHK("ack1", 1'b1, ack1_n)
        `CHK("pin3 oe", 1'b1, p3)
        `CHK("slave irq", 1'b0, irq)
        `CHK("enable", 1'b0, ie)
        `CHK("pending", 5'h00, pend)
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK("pin3 oe", 1'b0, p3)
    endtask : t_reset
    // level input 4 tracks its pin; boundary low holds every start off
    task automatic t_level;
        mode <= 2'h0;
        lvl <= 5'h10;
        bnd <= 1'b0;
        kick(5'h10, 2'h0);
        quiet(6);
        `CHK("pending", 5'h10, pend)
        @(posedge clk);
        bnd <= 1'b1;
        take_is(REQ_TYPE_BASE + 8'h04, 5'h10);
        quiet(4);
        `CHK("pending", 5'h00, pend)
    endtask : t_level
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_normal();
        t_nmi();
        t_cascade();
        t_slave();
        t_reset();
        t_level();
        tally_and_finish();
    end
endmodule : ipi_top_tb
